// >>> pkg/tws_pkg.sv
// Purpose: shared constants for the timer waveform shadow register bank
// Assumes: 32-bit APB data, one aligned word per register
// Notes: every offset, reset value and field position lives here; the period and pattern masks sit in tws_top

package tws_pkg;

  // ******************************************************************
  // register offsets (byte addresses)
  // ******************************************************************
  localparam logic [7:0] PATT_OFS = 8'h64; // pattern enable buffer
  localparam logic [7:0] WAVE_OFS = 8'h68; // waveform_shadow
  localparam logic [7:0] PER_OFS = 8'h6c; // cycle_length_shadow
  localparam logic [7:0] CTRL_OFS = 8'h80; // buffering control
  localparam logic [7:0] WSTAT_OFS = 8'h84; // active waveform image
  localparam logic [7:0] PSTAT_OFS = 8'h88; // active period image
  localparam logic [7:0] POSTAT_OFS = 8'h8c; // active pattern enables

  // ******************************************************************
  // widths
  // ******************************************************************
  localparam int CNT_W = 24; // counter size, period bits
  localparam int PAT_W = 8; // pattern output enables
  localparam int CH_W = 4; // per-channel / per-pair fields
  localparam int SLOPE_W = 2; // slope scheme
  localparam int MODE_W = 3; // waveform mode
  localparam int DITH_W = 6; // widest dither field

  // ******************************************************************
  // waveform buffer field positions and implemented bits
  // ******************************************************************
  localparam int SWAP_LSB = 24; // pair exchange
  localparam int SENSE_LSB = 16; // output sense
  localparam int CIRC_LSB = 8; // circular channel enables
  localparam int CLEN_BIT = 7; // circular length enable
  localparam int SLOPE_LSB = 4; // slope scheme
  localparam int MODE_LSB = 0; // waveform mode
  localparam logic [31:0] WAVE_MASK = 32'h0f0f0fb7;

  // ******************************************************************
  // control register fields
  // ******************************************************************
  localparam int CTRL_DBUF_BIT = 0; // double buffering enable
  localparam int CTRL_DITH_LSB = 1; // dither layout, 2 bits
  localparam logic [31:0] CTRL_MASK = 32'h00000007;

  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [31:0] WAVE_RESET = 32'h00000000;
  localparam logic [31:0] PER_RESET = 32'h0fffffff;
  localparam logic [31:0] PATT_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  // waveform mode codes
  typedef enum logic [2:0] {
    NORMAL_FREQUENCY_MODE = 3'h0,
    MATCH_FREQUENCY_MODE = 3'h1,
    NORMAL_PULSE_WIDTH_MODE = 3'h2,
    MODE_RESERVED = 3'h3,
    DUAL_SLOPE_CRITICAL_MODE = 3'h4,
    DUAL_SLOPE_LOW_EVENT_MODE = 3'h5,
    DUAL_SLOPE_BOTH_EVENT_MODE = 3'h6,
    DUAL_SLOPE_HIGH_EVENT_MODE = 3'h7
  } tws_wave_t;

  // slope scheme codes
  typedef enum logic [1:0] {
    SLOPE_SCHEME_ONE = 2'h0,
    SLOPE_SCHEME_TWO_ALT = 2'h1,
    SLOPE_SCHEME_TWO = 2'h2,
    SLOPE_RESERVED = 2'h3
  } tws_slope_t;

  // dither layouts of the period buffer
  typedef enum logic [1:0] {
    NO_DITHER_LAYOUT = 2'h0,
    FOUR_BIT_DITHER_LAYOUT = 2'h1,
    FIVE_BIT_DITHER_LAYOUT = 2'h2,
    SIX_BIT_DITHER_LAYOUT = 2'h3
  } tws_dith_t;

endpackage

// >>> pkg/tws_reg_if.sv
// Purpose: register access path between the bus slave and the bank
// Assumes: single clock, decode result returned combinationally
// Notes: wr_en is a one-cycle strobe at the write's completing edge

`timescale 1ns/1ps

interface tws_reg_if;
  logic [7:0] addr; // byte address
  logic [31:0] wdata; // write data
  logic wr_en; // write strobe
  logic [31:0] rdata; // read data for addr
  logic hit; // addr is mapped

  modport bus (output addr, output wdata, output wr_en,
               input rdata, input hit);
  modport regs (input addr, input wdata, input wr_en,
                output rdata, output hit);
endinterface

// >>> logic/tws_shadow_pair.sv
// Purpose: one buffer register and its active copy
// Assumes: load and wr_en come from logic on pclk
// Notes: a write and a load in one cycle moves the old buffer value

`timescale 1ns/1ps

module tws_shadow_pair #(
  parameter int W = 32,
  parameter logic [W-1:0] MASK = '1,
  parameter logic [W-1:0] RST_SHADOW = '0,
  parameter logic [W-1:0] RST_ACTIVE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [W-1:0] wdata,
  input wire logic load,
  output logic [W-1:0] shadow,
  output logic [W-1:0] active
);

  // ******************************************************************
  // buffer copy, software side
  // ******************************************************************
  // unimplemented bits are never stored, so they read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow <= RST_SHADOW & MASK;
    end else if (wr_en) begin
      shadow <= wdata & MASK;
    end
  end

  // ******************************************************************
  // active copy, taken whole on load
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= RST_ACTIVE & MASK;
    end else if (load) begin
      active <= shadow;
    end
  end

endmodule

// >>> logic/tws_apb_slave.sv
// Purpose: APB slave front end for the shadow register bank
// Assumes: zero wait states, read data captured in the setup cycle
// Notes: unmapped addresses answer with pslverr and no side effect

`timescale 1ns/1ps

module tws_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tws_reg_if.bus rif
);

  logic err_reg; // setup-cycle decode miss
  logic setup; // first cycle of a transfer
  logic access; // completing cycle

  assign setup = psel & ~penable;
  assign access = psel & penable;

  // ******************************************************************
  // decode path
  // ******************************************************************
  assign rif.addr = paddr;
  assign rif.wdata = pwdata;
  // write lands only at the completing edge of a mapped access
  assign rif.wr_en = access & pwrite & rif.hit;
  // never stretches the access phase
  assign pready = access;
  assign pslverr = access & err_reg;

  // ******************************************************************
  // read data and error flag, sampled in setup
  // ******************************************************************
  // registering here keeps prdata glitch-free at the cost of one
  // cycle of staleness for live status words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      err_reg <= 1'b0;
    end else if (setup) begin
      prdata <= (!pwrite && rif.hit) ? rif.rdata : 32'h00000000;
      err_reg <= ~rif.hit;
    end
  end

endmodule

// >>> logic/tws_top.sv
// Purpose: double-buffer register set of a 24-bit control timer
// Assumes: update_event is a pclk-domain pulse from the counter core
// Notes: all enabled fields move into their active copies together

`timescale 1ns/1ps

module tws_top #(
  parameter int CNT_W = tws_pkg::CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic update_event,
  output logic [7:0] pattern_output_enable_active,
  output logic [3:0] pair_exchange_active,
  output logic [3:0] output_sense_active,
  output logic [3:0] circular_channel_enable_active,
  output logic circular_length_enable_active,
  output logic [1:0] slope_scheme_active,
  output logic [2:0] waveform_mode_active,
  output logic dual_slope_mode,
  output logic [CNT_W-1:0] cycle_length_active,
  output logic [5:0] dither_count_active,
  output logic transfer_done
);

  // ******************************************************************
  // declarations
  // ******************************************************************
  localparam logic [CNT_W-1:0] PER_MASK = '1; // implemented period bits

  tws_reg_if rif (); // bus slave to bank path

  logic [31:0] ctrl_reg; // buffering control
  logic dbuf_en; // double buffering on
  tws_pkg::tws_dith_t dith_layout; // period buffer layout
  logic load; // copy strobe shared by every field
  logic [31:0] wave_shadow; // waveform buffer image
  logic [31:0] wave_active; // waveform active image
  logic [7:0] patt_shadow; // pattern enable buffer
  logic [CNT_W-1:0] per_shadow; // period buffer
  logic [5:0] dith_mask; // dither bits of current layout
  logic [5:0] dither_count_active_next; // dither field to load
  logic dual_slope_next; // decoded mode class
  logic [3:0] sh_swap; // buffer slices, checked below
  logic [3:0] sh_sense;
  logic [3:0] sh_circ;
  logic sh_clen;
  logic [1:0] sh_slope;
  logic [2:0] sh_mode;

  // ******************************************************************
  // bus slave
  // ******************************************************************
  tws_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif)
  );

  // ******************************************************************
  // control register
  // ******************************************************************
  // software steers buffering and the period layout from here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tws_pkg::CTRL_RESET;
    end else if (rif.wr_en && rif.addr == tws_pkg::CTRL_OFS) begin
      ctrl_reg <= rif.wdata & tws_pkg::CTRL_MASK;
    end
  end

  assign dbuf_en = ctrl_reg[tws_pkg::CTRL_DBUF_BIT];
  assign dith_layout = tws_pkg::tws_dith_t'(ctrl_reg[tws_pkg::CTRL_DITH_LSB
                                             +: 2]);

  // one strobe for all fields, so nothing can lag a cycle
  assign load = update_event & dbuf_en;

  // ******************************************************************
  // buffered registers
  // ******************************************************************
  // reserved waveform bits are masked at storage
  tws_shadow_pair #(
    .W(32),
    .MASK(tws_pkg::WAVE_MASK),
    .RST_SHADOW(tws_pkg::WAVE_RESET),
    .RST_ACTIVE(tws_pkg::WAVE_RESET)
  ) u_wave (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(rif.wr_en && rif.addr == tws_pkg::WAVE_OFS),
    .wdata(rif.wdata),
    .load(load),
    .shadow(wave_shadow),
    .active(wave_active)
  );

  // only the enable half of the pattern buffer lives here
  tws_shadow_pair #(
    .W(tws_pkg::PAT_W),
    .MASK(8'hff),
    .RST_SHADOW(tws_pkg::PATT_RESET[7:0]),
    .RST_ACTIVE(tws_pkg::PATT_RESET[7:0])
  ) u_patt (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(rif.wr_en && rif.addr == tws_pkg::PATT_OFS),
    .wdata(rif.wdata[7:0]),
    .load(load),
    .shadow(patt_shadow),
    .active(pattern_output_enable_active)
  );

  // period sized to the counter; the upper byte never stores
  tws_shadow_pair #(
    .W(CNT_W),
    .MASK(PER_MASK),
    .RST_SHADOW(tws_pkg::PER_RESET[CNT_W-1:0]),
    .RST_ACTIVE(tws_pkg::PER_RESET[CNT_W-1:0])
  ) u_per (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(rif.wr_en && rif.addr == tws_pkg::PER_OFS),
    .wdata(rif.wdata[CNT_W-1:0]),
    .load(load),
    .shadow(per_shadow),
    .active(cycle_length_active)
  );

  // ******************************************************************
  // active field slices
  // ******************************************************************
  assign pair_exchange_active = wave_active[tws_pkg::SWAP_LSB +: 4];
  assign output_sense_active = wave_active[tws_pkg::SENSE_LSB +: 4];
  assign circular_channel_enable_active =
    wave_active[tws_pkg::CIRC_LSB +: 4];
  assign circular_length_enable_active = wave_active[tws_pkg::CLEN_BIT];
  assign slope_scheme_active = wave_active[tws_pkg::SLOPE_LSB +: 2];
  assign waveform_mode_active = wave_active[tws_pkg::MODE_LSB +: 3];

  assign sh_swap = wave_shadow[tws_pkg::SWAP_LSB +: 4];
  assign sh_sense = wave_shadow[tws_pkg::SENSE_LSB +: 4];
  assign sh_circ = wave_shadow[tws_pkg::CIRC_LSB +: 4];
  assign sh_clen = wave_shadow[tws_pkg::CLEN_BIT];
  assign sh_slope = wave_shadow[tws_pkg::SLOPE_LSB +: 2];
  assign sh_mode = wave_shadow[tws_pkg::MODE_LSB +: 3];

  // ******************************************************************
  // dither field and mode class
  // ******************************************************************
  // low period bits double as the dither count in dither layouts
  always_comb begin
    unique case (dith_layout)
      tws_pkg::FOUR_BIT_DITHER_LAYOUT: dith_mask = 6'h0f;
      tws_pkg::FIVE_BIT_DITHER_LAYOUT: dith_mask = 6'h1f;
      tws_pkg::SIX_BIT_DITHER_LAYOUT: dith_mask = 6'h3f;
      default: dith_mask = 6'h00; // no dithering
    endcase
    dither_count_active_next = per_shadow[5:0] & dith_mask;
    // top bit of the mode code marks the dual-slope family
    unique case (tws_pkg::tws_wave_t'(sh_mode))
      tws_pkg::DUAL_SLOPE_CRITICAL_MODE,
      tws_pkg::DUAL_SLOPE_LOW_EVENT_MODE,
      tws_pkg::DUAL_SLOPE_BOTH_EVENT_MODE,
      tws_pkg::DUAL_SLOPE_HIGH_EVENT_MODE: dual_slope_next = 1'b1;
      default: dual_slope_next = 1'b0;
    endcase
  end

  // dither count rides the same strobe as the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dither_count_active <= 6'h00;
    end else if (load) begin
      dither_count_active <= dither_count_active_next;
    end
  end

  // mode class registered alongside the mode itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_slope_mode <= 1'b0;
    end else if (load) begin
      dual_slope_mode <= dual_slope_next;
    end
  end

  // one-cycle mark that the active set just changed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_done <= 1'b0;
    end else begin
      transfer_done <= load;
    end
  end

  // ******************************************************************
  // read mux
  // ******************************************************************
  // narrower registers sit low; bits above read zero
  always_comb begin
    rif.hit = 1'b1;
    unique case (rif.addr)
      tws_pkg::PATT_OFS: rif.rdata = {24'h000000, patt_shadow};
      tws_pkg::WAVE_OFS: rif.rdata = wave_shadow;
      tws_pkg::PER_OFS: rif.rdata = 32'(per_shadow);
      tws_pkg::CTRL_OFS: rif.rdata = ctrl_reg;
      tws_pkg::WSTAT_OFS: rif.rdata = wave_active;
      tws_pkg::PSTAT_OFS: rif.rdata = 32'(cycle_length_active);
      tws_pkg::POSTAT_OFS: rif.rdata =
        {24'h000000, pattern_output_enable_active};
      default: begin
        rif.rdata = 32'h00000000; // unmapped
        rif.hit = 1'b0;
      end
    endcase
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PATTERN_COPY: assert property (
    load |=> pattern_output_enable_active == $past(patt_shadow))
    else $error("pattern enables not copied on update");

  AST_EXCHANGE_COPY: assert property (
    load |=> pair_exchange_active == $past(sh_swap))
    else $error("pair exchange not copied on update");

  AST_SENSE_COPY: assert property (
    load |=> output_sense_active == $past(sh_sense))
    else $error("output sense not copied on update");

  AST_CIRC_COPY: assert property (
    load |=> circular_channel_enable_active == $past(sh_circ))
    else $error("circular channel enables not copied");

  AST_CLEN_COPY: assert property (
    load |=> circular_length_enable_active == $past(sh_clen))
    else $error("circular length enable not copied");

  AST_SLOPE_COPY: assert property (
    load |=> slope_scheme_active == $past(sh_slope))
    else $error("slope scheme not copied on update");

  AST_MODE_COPY: assert property (
    load |=> waveform_mode_active == $past(sh_mode))
    else $error("waveform mode not copied on update");

  AST_DUAL_SLOPE: assert property (
    transfer_done |-> dual_slope_mode == waveform_mode_active[2])
    else $error("dual-slope class disagrees with mode");

  AST_RESERVED_ZERO: assert property (
    psel && !penable && !pwrite && paddr == tws_pkg::WAVE_OFS
    |=> (prdata & ~tws_pkg::WAVE_MASK) == 32'h00000000)
    else $error("reserved waveform bits read nonzero");

  AST_PERIOD_WIDTH: assert property (
    psel && !penable && !pwrite && paddr == tws_pkg::PER_OFS
    |=> prdata[31:24] == 8'h00 && prdata[23:0] == $past(per_shadow))
    else $error("period buffer read wrong");

  AST_DITHER_FOUR: assert property (
    load && dith_layout == tws_pkg::FOUR_BIT_DITHER_LAYOUT
    |=> dither_count_active == {2'b00, $past(per_shadow[3:0])})
    else $error("dither count not copied on update");

  AST_HOLD_TOGETHER: assert property (
    !load |=> $stable(wave_active) && $stable(cycle_length_active)
      && $stable(pattern_output_enable_active) ##0 !transfer_done)
    else $error("active set changed without an update");

  AST_DISABLED_NO_COPY: assert property (
    update_event && !dbuf_en |=> !transfer_done && $stable(wave_active)
      && $stable(cycle_length_active))
    else $error("copy happened with buffering off");

endmodule

// >>> bench/tws_top_bench.sv
// Purpose: self-checking bench for the timer shadow register bank
// Assumes: zero-wait APB slave, update pulses driven by the bench
// Notes: only mismatches and the verdict are printed

`timescale 1ns/1ps

module tws_top_bench;
  // ******************************************************************
  // clock, reset and design signals
  // ******************************************************************
  logic pclk = 1'b0; // 200 MHz bus clock
  logic presetn = 1'b0; // held low for 20 cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic update_event = 1'b0; // stands in for the counter core
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pattern_output_enable_active;
  logic [3:0] pair_exchange_active;
  logic [3:0] output_sense_active;
  logic [3:0] circular_channel_enable_active;
  logic circular_length_enable_active;
  logic [1:0] slope_scheme_active;
  logic [2:0] waveform_mode_active;
  logic dual_slope_mode;
  logic [23:0] cycle_length_active;
  logic [5:0] dither_count_active;
  logic transfer_done;
  logic [31:0] wave_act; // actives packed like the buffer word
  int bad_count = 0;
  int n_tests = 0;

  // repacking lets one compare cover every waveform field at once
  assign wave_act = {4'h0, pair_exchange_active, 4'h0, output_sense_active,
    4'h0, circular_channel_enable_active, circular_length_enable_active,
    1'b0, slope_scheme_active, 1'b0, waveform_mode_active};

  // free-running clock, 5 ns period
  always #2.5 pclk = ~pclk;

  tws_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .update_event(update_event),
    .pattern_output_enable_active(pattern_output_enable_active),
    .pair_exchange_active(pair_exchange_active),
    .output_sense_active(output_sense_active),
    .circular_channel_enable_active(circular_channel_enable_active),
    .circular_length_enable_active(circular_length_enable_active),
    .slope_scheme_active(slope_scheme_active),
    .waveform_mode_active(waveform_mode_active),
    .dual_slope_mode(dual_slope_mode),
    .cycle_length_active(cycle_length_active),
    .dither_count_active(dither_count_active),
    .transfer_done(transfer_done)
  );

  // ******************************************************************
  // compare, bus and update helpers
  // ******************************************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk_flag(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk_word(r, exp);
    chk_flag(e, 1'b0);
  endtask

  // one-cycle update; returns mid-cycle after the copy edge
  task automatic pulse_update();
    @(posedge pclk);
    update_event <= 1'b1;
    @(posedge pclk);
    update_event <= 1'b0;
    #1;
  endtask

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd_chk(tws_pkg::WAVE_OFS, 32'h00000000);
    rd_chk(tws_pkg::PER_OFS, 32'h00ffffff);
    rd_chk(tws_pkg::PATT_OFS, 32'h00000000);
    rd_chk(tws_pkg::CTRL_OFS, 32'h00000001);
    chk_word({8'h00, cycle_length_active}, 32'h00ffffff);
    // every implemented bit set, reserved places kept zero by software
    wr(tws_pkg::WAVE_OFS, 32'h0f0f0fb7);
    rd_chk(tws_pkg::WAVE_OFS, 32'h0f0f0fb7);
    wr(tws_pkg::PER_OFS, 32'h00123456);
    rd_chk(tws_pkg::PER_OFS, 32'h00123456);
    apb(1'b0, 8'h90, 32'h00000000, r, e);
    chk_flag(e, 1'b1);
    chk_word(r, 32'h00000000);
  endtask

  task automatic t_update();
    wr(tws_pkg::WAVE_OFS, 32'h0a050ca6);
    wr(tws_pkg::PATT_OFS, 32'h0000005a);
    wr(tws_pkg::PER_OFS, 32'h00abcdef);
    chk_word(wave_act, 32'h00000000);
    pulse_update();
    chk_word(wave_act, 32'h0a050ca6);
    chk_word({24'h0, pattern_output_enable_active}, 32'h5a);
    chk_word({8'h00, cycle_length_active}, 32'h00abcdef);
    chk_flag(transfer_done, 1'b1);
    @(posedge pclk);
    #1;
    chk_flag(transfer_done, 1'b0);
    // read-only images of the active set must mirror the outputs
    rd_chk(tws_pkg::WSTAT_OFS, 32'h0a050ca6);
    rd_chk(tws_pkg::PSTAT_OFS, 32'h00abcdef);
    rd_chk(tws_pkg::POSTAT_OFS, 32'h0000005a);
  endtask

  // every mode code goes through once and every slope code twice
  task automatic t_codes();
    logic [31:0] w;
    for (int i = 0; i < 8; i++) begin
      w = {26'h0, i[1:0], 1'b0, i[2:0]};
      wr(tws_pkg::WAVE_OFS, w);
      pulse_update();
      chk_word({29'h0, waveform_mode_active}, {29'h0, i[2:0]});
      chk_word({30'h0, slope_scheme_active}, {30'h0, i[1:0]});
      chk_flag(dual_slope_mode, i >= 4);
    end
  endtask

  // buffering off freezes the actives, on again releases them
  task automatic t_disabled();
    wr(tws_pkg::CTRL_OFS, 32'h00000000);
    wr(tws_pkg::WAVE_OFS, 32'h05000000);
    wr(tws_pkg::PATT_OFS, 32'h000000ff);
    pulse_update();
    chk_word(wave_act, 32'h00000037);
    chk_word({24'h0, pattern_output_enable_active}, 32'h5a);
    chk_flag(transfer_done, 1'b0);
    wr(tws_pkg::CTRL_OFS, 32'h00000001);
    pulse_update();
    chk_word(wave_act, 32'h05000000);
    chk_word({24'h0, pattern_output_enable_active}, 32'hff);
  endtask

  // low bits of 0xb5 differ for four, five and six bit layouts
  task automatic t_dither();
    logic [31:0] exp;
    for (int lay = 1; lay < 4; lay++) begin
      wr(tws_pkg::CTRL_OFS, {29'h0, lay[1:0], 1'b1});
      wr(tws_pkg::PER_OFS, 32'h00fedcb5);
      pulse_update();
      exp = 32'h00fedcb5 & ((32'h1 << (lay + 3)) - 32'h1);
      chk_word({26'h0, dither_count_active}, exp);
      chk_word({8'h00, cycle_length_active}, 32'h00fedcb5);
    end
    wr(tws_pkg::CTRL_OFS, 32'h00000001);
  endtask

  // ******************************************************************
  // verdict, watchdog and main sequence
  // ******************************************************************
  task automatic final_report();
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the whole run needs about 150 cycles; 20000 is ample
  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_update();
    t_codes();
    t_disabled();
    t_dither();
    final_report();
  end
endmodule
